// ==== common/cti_pkg.sv ====
/*
  Shared constants and types for the configurable time-slot interface front end:
  register offsets, field positions, reset values, modes, bandwidth codes.
  Assumes a single system clock domain; line-side signals are synchronised by the core.
*/
package cti_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] CTI_ADDR_MODE1 = 4'h0;
  localparam logic [3:0] CTI_ADDR_MODE2 = 4'h1;
  localparam logic [3:0] CTI_ADDR_BITS_LO = 4'h2;
  localparam logic [3:0] CTI_ADDR_SHIFT = 4'h3;
  localparam logic [3:0] CTI_ADDR_ADJUST = 4'h4;
  localparam logic [3:0] CTI_ADDR_SUBSEL = 4'h5;
  localparam logic [3:0] CTI_ADDR_OPMODE = 4'h6;
  localparam logic [3:0] CTI_ADDR_STATUS = 4'h7;

  // reset values
  localparam logic [4:0] CTI_MODE1_RST = 5'h00;
  localparam logic [7:0] CTI_MODE2_RST = 8'h00;
  localparam logic [7:0] CTI_BITS_LO_RST = 8'hff;
  localparam logic [6:0] CTI_SHIFT_RST = 7'h20;
  localparam logic [6:0] CTI_ADJUST_RST = 7'h02;
  localparam logic [7:0] CTI_SUBSEL_RST = 8'h00;
  localparam logic [7:0] CTI_OPMODE_RST = 8'h00;

  // field positions, mode register one
  localparam int CTI_M1_MODE_LSB = 0;
  localparam int CTI_M1_RX_SEL0 = 2;
  localparam int CTI_M1_RX_SEL1 = 3;
  localparam int CTI_M1_SYNC_SRC = 4;
  // mode register two
  localparam int CTI_M2_SHAPE_LSB = 5;
  localparam int CTI_M2_OUT_CLK = 4;
  localparam int CTI_M2_TX_EDGE = 3;
  localparam int CTI_M2_RX_EDGE = 2;
  localparam int CTI_M2_BITS_HI_LSB = 0;
  // frame shift register
  localparam int CTI_SH_DS_LSB = 4;
  localparam int CTI_SH_US_LSB = 0;
  // operation mode register
  localparam int CTI_OM_DRIVER = 3;

  // two slots of adjust bias times 8 bits, plus the zero-offset shift code 2
  localparam logic [11:0] CTI_MARK_BIAS = 12'h012;

  // synchroniser vector layout
  localparam int CTI_SY_DU_LSB = 0;
  localparam int CTI_SY_DD_LSB = 4;
  localparam int CTI_SY_CLK = 8;
  localparam int CTI_SY_PCM_FP = 9;
  localparam int CTI_SY_LINE_FP = 10;
  localparam int CTI_SY_W = 11;

  typedef enum logic [1:0] {
    CTI_MODE_QUAD = 2'h0,
    CTI_MODE_DUAL = 2'h1,
    CTI_MODE_SINGLE = 2'h2,
    CTI_MODE_OCTAL = 2'h3
  } cti_mode_e;

  typedef enum logic [1:0] {
    CTI_BW_NONE = 2'h0,
    CTI_BW_16K = 2'h1,
    CTI_BW_32K = 2'h2,
    CTI_BW_64K = 2'h3
  } cti_bw_e;

  // one slot's worth of memory data plus the connection's bandwidth code
  typedef struct packed {
    logic [7:0] data;
    cti_bw_e bw;
  } cti_slot_s;

endpackage

// ==== core/cti_subch.sv ====
/*
  Subchannel positioner for one logical port and direction: bit mask of the
  active subchannel, placement of right-aligned memory data and extraction.
  Purely combinational; the caller supplies select and bandwidth code.
*/
`timescale 1ns/1ps
module cti_subch
  import cti_pkg::*;
(
  input wire logic [1:0] i_sel,
  input wire cti_bw_e i_bw,
  input wire logic [7:0] i_data,
  output logic [7:0] o_mask,
  output logic [7:0] o_place,
  output logic [7:0] o_take
);

  logic [2:0] lsb;

  always_comb begin
    lsb = {~i_sel, 1'b0};
    o_mask = 8'h00;
    o_place = 8'h00;
    o_take = 8'h00;
    case (i_bw)
      CTI_BW_64K: begin
        o_mask = 8'hff;
        o_place = i_data;
        o_take = i_data;
      end
      CTI_BW_32K: begin
        if (i_sel[0]) begin
          o_mask = 8'h0f;
          o_place = {4'h0, i_data[3:0]};
          o_take = {4'h0, i_data[3:0]};
        end else begin
          o_mask = 8'hf0;
          o_place = {i_data[3:0], 4'h0};
          o_take = {4'h0, i_data[7:4]};
        end
      end
      CTI_BW_16K: begin
        o_mask = 8'h03 << lsb;
        o_place = {6'h00, i_data[1:0]} << lsb;
        o_take = (i_data >> lsb) & 8'h03;
      end
      default: begin
        o_mask = 8'h00;
      end
    endcase
  end

endmodule

// ==== core/cti_port_map.sv ====
/*
  Configurable time-slot interface front end: maps logical ports to the
  physical up/downstream lines per interface mode, positions subchannels in
  each slot, applies frame offset, upstream shift and clock edge settings.
  Assumes the line bit clock and frame pulses are asynchronous pins, much
  slower than i_sys_clk (at least four system clocks per phase), and that
  the memory side answers slot numbers combinationally.
*/
`timescale 1ns/1ps
// Functional notes
// - transmit of each port fixed to its pin
// - mode 1: rx select bits pick lines
// - mode 2: select bit 0 picks line
// - pin drive roles depend on mode
// - memory code sets bandwidth, register sets position
// - select code picks subchannel bit positions
// - select per port, pairs in mode 3
// - one subchannel per slot, rest inactive
// - code 000 marks bit 1, previous slot
// - upstream frame shifts left up to 15
// - shift code moves both frames
// - zero upstream shift keeps frames aligned
// - push-pull drives data, idle high impedance
module cti_port_map
  import cti_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_line_bit_clock,
  input wire logic i_pcm_frame_pulse,
  input wire logic i_line_frame_pulse,
  input wire logic [3:0] i_up_line,
  output logic [3:0] o_up_line,
  output logic [3:0] o_up_line_oe,
  input wire logic [3:0] i_down_line,
  output logic [3:0] o_down_line,
  output logic [3:0] o_down_line_oe,
  output logic [6:0] o_tx_slot,
  input wire cti_slot_s [7:0] i_tx,
  output logic [6:0] o_rx_cur_slot,
  input wire cti_bw_e [7:0] i_rx_bw,
  output logic [7:0][7:0] o_rx_data,
  output logic [6:0] o_rx_slot,
  output logic o_rx_valid
);

  typedef struct packed {
    logic [4:0] mode1;
    logic [7:0] mode2;
    logic [7:0] bits_lo;
    logic [6:0] shift;
    logic [6:0] adjust;
    logic [7:0] subsel;
    logic [7:0] opmode;
    logic [7:0] rdata;
    logic [CTI_SY_W-1:0] sync1;
    logic [CTI_SY_W-1:0] sync2;
    logic clk_prev;
    logic fp_prev;
    logic fp_pend;
    logic [9:0] ds_cnt;
    logic [9:0] us_cnt;
    logic [6:0] tx_slot;
    logic [7:0][7:0] tx_byte;
    logic [7:0][7:0] tx_mask;
    logic [7:0][7:0] rx_sh;
    logic [3:0] dd_o;
    logic [3:0] dd_oe;
    logic [3:0] du_o;
    logic [3:0] du_oe;
    logic [7:0][7:0] rx_data;
    logic rx_valid;
    logic [6:0] rx_slot;
  } cti_state_s;

  cti_state_s st;
  cti_state_s next_st;

  logic [7:0][7:0] tx_mask_w;
  logic [7:0][7:0] tx_place_w;
  logic [7:0][7:0] rx_take_w;
  logic [7:0][7:0] rx_byte_w;

  // each select pair serves port p and, in the eight-port mode, port p+4
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_port
      cti_subch u_tx (
        .i_sel(st.subsel[2*(gp%4) +: 2]),
        .i_bw(i_tx[gp].bw),
        .i_data(i_tx[gp].data),
        .o_mask(tx_mask_w[gp]),
        .o_place(tx_place_w[gp]),
        .o_take()
      );
      cti_subch u_rx (
        .i_sel(st.subsel[2*(gp%4) +: 2]),
        .i_bw(i_rx_bw[gp]),
        .i_data(rx_byte_w[gp]),
        .o_mask(),
        .o_place(),
        .o_take(rx_take_w[gp])
      );
    end
  endgenerate

  cti_mode_e mode;
  logic clk_now;
  logic clk_rise;
  logic clk_fall;
  logic tx_ev;
  logic rx_ev;
  logic fp_lvl;
  logic [10:0] nbits;
  logic [11:0] mark;
  logic [11:0] up_pos;
  logic [11:0] step;
  logic [11:0] ahead;
  logic [9:0] ds_new;
  logic [9:0] us_new;
  logic [2:0] bidx;
  logic [3:0] du_s;
  logic [3:0] dd_s;
  logic [7:0] rx_bit;
  logic [7:0] port_on;
  logic tbit;
  logic tm;
  logic drv;
  logic dat;

  assign mode = cti_mode_e'(st.mode1[CTI_M1_MODE_LSB +: 2]);
  assign nbits = {1'b0, st.mode2[CTI_M2_BITS_HI_LSB +: 2], st.bits_lo} + 11'h001;
  assign du_s = st.sync2[CTI_SY_DU_LSB +: 4];
  assign dd_s = st.sync2[CTI_SY_DD_LSB +: 4];

  // assembled receive byte for the bit being sampled now
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      rx_byte_w[p] = {st.rx_sh[p][6:0], rx_bit[p]};
    end
  end

  // receive line per logical port
  always_comb begin
    rx_bit = 8'h00;
    case (mode)
      CTI_MODE_QUAD: begin
        rx_bit[3:0] = du_s;
      end
      CTI_MODE_DUAL: begin
        rx_bit[0] = st.mode1[CTI_M1_RX_SEL0] ? du_s[2] : du_s[0];
        rx_bit[1] = st.mode1[CTI_M1_RX_SEL1] ? du_s[3] : du_s[1];
      end
      // single port, select bit 0 only
      CTI_MODE_SINGLE: begin
        rx_bit[0] = st.mode1[CTI_M1_RX_SEL0] ? du_s[2] : du_s[0];
      end
      // octal mode, lines read back as inputs
      CTI_MODE_OCTAL: begin
        rx_bit = {du_s, dd_s};
      end
      default: begin
        rx_bit = 8'h00;
      end
    endcase
  end

  // logical ports that exist in each mode
  always_comb begin
    case (mode)
      CTI_MODE_QUAD: port_on = 8'h0f;
      CTI_MODE_DUAL: port_on = 8'h03;
      CTI_MODE_SINGLE: port_on = 8'h01;
      CTI_MODE_OCTAL: port_on = 8'hff;
      default: port_on = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.sync1 = {i_line_frame_pulse, i_pcm_frame_pulse, i_line_bit_clock,
                     i_down_line, i_up_line};
    next_st.sync2 = st.sync1;
    clk_now = st.sync2[CTI_SY_CLK];
    next_st.clk_prev = clk_now;
    clk_rise = clk_now & ~st.clk_prev;
    clk_fall = ~clk_now & st.clk_prev;
    // edge choice for transmit and sampling
    tx_ev = st.mode2[CTI_M2_TX_EDGE] ? clk_fall : clk_rise;
    rx_ev = st.mode2[CTI_M2_RX_EDGE] ? clk_rise : clk_fall;
    fp_lvl = st.mode1[CTI_M1_SYNC_SRC] ? st.sync2[CTI_SY_LINE_FP] : st.sync2[CTI_SY_PCM_FP];
    next_st.rx_valid = 1'b0;

    // register port
    next_st.rdata = 8'h00;
    if (i_wr) begin
      case (i_addr)
        CTI_ADDR_MODE1: next_st.mode1 = i_wdata[4:0];
        // shape, clock, edges, frame length high
        CTI_ADDR_MODE2: next_st.mode2 = i_wdata;
        CTI_ADDR_BITS_LO: next_st.bits_lo = i_wdata;
        // down code 6:4, up shift 3:0
        CTI_ADDR_SHIFT: next_st.shift = i_wdata[6:0];
        CTI_ADDR_ADJUST: next_st.adjust = i_wdata[6:0];
        CTI_ADDR_SUBSEL: next_st.subsel = i_wdata;
        CTI_ADDR_OPMODE: next_st.opmode = i_wdata;
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        CTI_ADDR_MODE1: next_st.rdata = {3'h0, st.mode1};
        CTI_ADDR_MODE2: next_st.rdata = st.mode2;
        CTI_ADDR_BITS_LO: next_st.rdata = st.bits_lo;
        CTI_ADDR_SHIFT: next_st.rdata = {1'b0, st.shift};
        CTI_ADDR_ADJUST: next_st.rdata = {1'b0, st.adjust};
        CTI_ADDR_SUBSEL: next_st.rdata = st.subsel;
        CTI_ADDR_OPMODE: next_st.rdata = st.opmode;
        CTI_ADDR_STATUS: next_st.rdata = {1'b0, st.ds_cnt[9:3]};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // frame pulse seen on a rising line clock edge; applied at next transmit edge
    if (clk_rise) begin
      next_st.fp_prev = fp_lvl;
      if (fp_lvl && !st.fp_prev) begin
        next_st.fp_pend = 1'b1;
      end
    end

    // mark position = (adjust-2)*8 + code - 2, modulo frame
    mark = 12'({st.adjust, 3'h0}) + 12'(st.shift[CTI_SH_DS_LSB +: 3])
           + 12'(nbits) - CTI_MARK_BIAS;
    if (mark >= 12'(nbits)) begin
      mark = mark - 12'(nbits);
    end
    // upstream runs ahead by the extra shift
    up_pos = mark + 12'(st.shift[CTI_SH_US_LSB +: 4]);
    if (up_pos >= 12'(nbits)) begin
      up_pos = up_pos - 12'(nbits);
    end
    step = 12'(st.ds_cnt) + 12'h001;
    if (step >= 12'(nbits)) begin
      step = 12'h000;
    end
    ds_new = step[9:0];
    step = 12'(st.us_cnt) + 12'h001;
    if (step >= 12'(nbits)) begin
      step = 12'h000;
    end
    us_new = step[9:0];
    if (st.fp_pend) begin
      ds_new = mark[9:0];
      us_new = up_pos[9:0];
    end
    ahead = 12'(ds_new) + 12'h008;
    if (ahead >= 12'(nbits)) begin
      ahead = ahead - 12'(nbits);
    end
    bidx = ~ds_new[2:0];
    tbit = 1'b0;
    tm = 1'b0;
    drv = 1'b0;
    dat = 1'b0;

    if (tx_ev) begin
      // a pulse caught on this very edge must survive for the next event
      next_st.fp_pend = next_st.fp_pend & ~st.fp_pend;
      next_st.ds_cnt = ds_new;
      next_st.us_cnt = us_new;
      next_st.tx_slot = ahead[9:3];
      for (int p = 0; p < 8; p++) begin
        // memory code gives bandwidth, select gives position
        if (ds_new[2:0] == 3'h0) begin
          next_st.tx_byte[p] = tx_place_w[p];
          next_st.tx_mask[p] = tx_mask_w[p];
        end
        tbit = next_st.tx_byte[p][bidx];
        // bits outside the subchannel stay inactive
        tm = next_st.tx_mask[p][bidx] & port_on[p];
        // push-pull drives both levels, open drain only zeros
        if (st.opmode[CTI_OM_DRIVER]) begin
          drv = tm & ~tbit;
          dat = 1'b0;
        end else begin
          drv = tm;
          dat = tbit;
        end
        // fixed pin per logical transmit port
        if (p < 4) begin
          next_st.dd_o[p] = dat;
          next_st.dd_oe[p] = drv;
        end else begin
          next_st.du_o[p-4] = dat;
          next_st.du_oe[p-4] = drv;
        end
      end
    end

    if (rx_ev) begin
      for (int p = 0; p < 8; p++) begin
        next_st.rx_sh[p] = rx_byte_w[p];
      end
      if (st.us_cnt[2:0] == 3'h7) begin
        for (int p = 0; p < 8; p++) begin
          next_st.rx_data[p] = port_on[p] ? rx_take_w[p] : 8'h00;
        end
        next_st.rx_valid = 1'b1;
        next_st.rx_slot = st.us_cnt[9:3];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= '0;
      st.mode1 <= CTI_MODE1_RST;
      st.mode2 <= CTI_MODE2_RST;
      st.bits_lo <= CTI_BITS_LO_RST;
      st.shift <= CTI_SHIFT_RST;
      st.adjust <= CTI_ADJUST_RST;
      st.subsel <= CTI_SUBSEL_RST;
      st.opmode <= CTI_OPMODE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_down_line = st.dd_o;
  assign o_down_line_oe = st.dd_oe;
  assign o_up_line = st.du_o;
  assign o_up_line_oe = st.du_oe;
  assign o_tx_slot = st.tx_slot;
  assign o_rx_cur_slot = st.us_cnt[9:3];
  assign o_rx_data = st.rx_data;
  assign o_rx_slot = st.rx_slot;
  assign o_rx_valid = st.rx_valid;

endmodule

// ==== tb/cti_port_map_monitor.sv ====
/* port checker for cti_port_map, attached by bind.
   assumes one system clock domain and sees only the top ports */
`timescale 1ns/1ps
module cti_port_map_monitor
  import cti_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_line_bit_clock,
  input wire logic [3:0] o_up_line_oe,
  input wire logic [3:0] o_down_line,
  input wire logic [3:0] o_down_line_oe,
  input wire logic o_rx_valid
);
  logic [7:0] sub;
  logic [1:0] mode;
  logic od;
  logic lc_q;
  logic [4:0] since;
  logic [4:0] quiet;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // pins only settle at the next transmit event, so wait out writes
  always_ff @(posedge i_sys_clk) begin
    lc_q <= i_line_bit_clock;
    since <= (i_rst || i_line_bit_clock != lc_q) ? 5'h00 : since + 5'(since != 5'h1f);
    quiet <= (i_rst || i_wr) ? 5'h00 : quiet + 5'(quiet != 5'h1f);
    if (i_rst) begin
      sub <= CTI_SUBSEL_RST;
      mode <= 2'h0;
      od <= 1'b0;
    end else if (i_wr && i_addr == CTI_ADDR_SUBSEL) begin
      sub <= i_wdata;
    end else if (i_wr && i_addr == CTI_ADDR_MODE1) begin
      mode <= i_wdata[1:0];
    end else if (i_wr && i_addr == CTI_ADDR_OPMODE) begin
      od <= i_wdata[CTI_OM_DRIVER];
    end
  end
  sequence s_sub_read;
    i_rd && i_addr == CTI_ADDR_SUBSEL;
  endsequence
  sequence s_after_edge;
    since <= 5'h06;
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (i_rd && i_addr[3] |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_subsel_back: assert property (s_sub_read |=> o_rdata == sub)
    else $error("subchannel select read back wrong");
  a_rx_pulse: assert property (o_rx_valid |-> s_after_edge ##1 !o_rx_valid)
    else $error("receive strobe not a pulse after a line edge");
  a_pin_timing: assert property ($changed({o_down_line, o_down_line_oe}) |-> s_after_edge)
    else $error("downstream pins moved without a line edge");
  a_quad_pins: assert property (quiet > 5'h14 && mode == 2'h0 |-> o_up_line_oe == 4'h0)
    else $error("upstream pins driven in mode 0");
  a_dual_pins: assert property (quiet > 5'h14 && mode == 2'h1 |->
    o_down_line_oe[3:2] == 2'h0 && o_up_line_oe == 4'h0)
    else $error("unused pins driven in mode 1");
  a_single_pins: assert property (quiet > 5'h14 && mode == 2'h2 |->
    o_down_line_oe[3:1] == 3'h0)
    else $error("unused pins driven in mode 2");
  a_open_drain: assert property (quiet > 5'h14 && od |->
    (o_down_line & o_down_line_oe) == 4'h0)
    else $error("open drain pin driven high");
endmodule
bind cti_port_map cti_port_map_monitor u_mon (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_line_bit_clock(i_line_bit_clock),
  .o_up_line_oe(o_up_line_oe), .o_down_line(o_down_line), .o_down_line_oe(o_down_line_oe),
  .o_rx_valid(o_rx_valid));

// ==== tb/cti_line_model.sv ====
/* line transceiver model: bit clock, frame pulse, upstream bits, and a
   record of downstream pin state per frame position.
   assumes 32-bit frames, data sent on rising and read on falling edge */
`timescale 1ns/1ps
module cti_line_model
  import cti_pkg::*;
(
  input wire logic i_run,
  input wire logic [4:0] i_mark,
  input wire logic [3:0] i_ushift,
  input wire logic [3:0][3:0][7:0] i_up_bytes,
  input wire logic [3:0] i_down,
  input wire logic [3:0] i_down_oe,
  output logic o_clk,
  output logic o_frame,
  output logic [3:0] o_up
);
  logic [7:0] seen [32];
  int k;
  int q;
  initial begin
    o_clk = 1'b0;
    o_frame = 1'b1;
    o_up = 4'hf;
    k = -1;
    wait (i_run);
    // odd offset keeps line edges off the system clock grid
    #13;
    forever begin
      #200;
      o_clk = 1'b1;
      k = k + 1;
      // pins still hold the bit sent after the previous edge
      if (k >= 2) seen[(k - 2 + i_mark) % 32] = {i_down_oe, i_down};
      // upstream leads by the extra shift
      q = (k - 1 + i_mark + i_ushift) % 32;
      if (k >= 1) for (int p = 0; p < 4; p++) o_up[p] = i_up_bytes[q / 8][p][7 - q % 8];
      #200;
      o_clk = 1'b0;
      // pulse marks the bit after the next rising edge
      o_frame = (k % 32 == 31);
    end
  end
endmodule

// ==== tb/tb.sv ====
/* self-checking bench for cti_port_map: registers, then traffic in
   modes 0 to 2 against the line model; assumes 32-bit frames */
`timescale 1ns/1ps
module tb;
  import cti_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic run = 1'b0;
  logic sync = 1'b0;
  logic chk_en = 1'b0;
  logic [4:0] mark = 5'h00;
  logic [3:0] ushift = 4'h0;
  logic [7:0] o_rdata;
  logic [7:0] v;
  logic [3:0] o_down_line, o_down_line_oe, dn, up;
  logic [6:0] o_tx_slot, o_rx_slot;
  logic [7:0][7:0] o_rx_data;
  logic o_rx_valid, frame, line_clk;
  logic [3:0][3:0][7:0] up_bytes = '0;
  logic [7:0] tx_tab [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rst_v [7] = '{8'h00, 8'h00, 8'hff, 8'h20, 8'h02, 8'h00, 8'h00};
  logic [7:0] rw_m [6] = '{8'h1f, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff};
  cti_slot_s [7:0] tx;
  cti_bw_e [7:0] rx_bw;
  int sel [4] = '{0, 0, 0, 0};
  int bw [4] = '{0, 0, 0, 0};
  int mode, cis, od;
  int failures = 0;
  int check_count = 0;
  int seed = 32'h93f0;
  always #25 i_sys_clk = ~i_sys_clk;
  // pull-ups on the downstream lines
  assign dn = (o_down_line_oe & o_down_line) | ~o_down_line_oe;
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      tx[p].data = tx_tab[o_tx_slot[1:0]] ^ 8'(p);
      tx[p].bw = cti_bw_e'(bw[p % 4]);
      rx_bw[p] = cti_bw_e'(bw[p % 4]);
    end
  end
  cti_port_map dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_line_bit_clock(line_clk),
    .i_pcm_frame_pulse(frame & ~sync), .i_line_frame_pulse(frame & sync),
    .i_up_line(up), .o_up_line(), .o_up_line_oe(), .i_down_line(dn),
    .o_down_line(o_down_line), .o_down_line_oe(o_down_line_oe), .o_tx_slot(o_tx_slot),
    .i_tx(tx), .o_rx_cur_slot(), .i_rx_bw(rx_bw), .o_rx_data(o_rx_data),
    .o_rx_slot(o_rx_slot), .o_rx_valid(o_rx_valid));
  cti_line_model far (
    .i_run(run), .i_mark(mark), .i_ushift(ushift), .i_up_bytes(up_bytes), .i_down(dn),
    .i_down_oe(o_down_line_oe), .o_clk(line_clk), .o_frame(frame), .o_up(up));
  function automatic int msk(int s, int b);
    return b == 3 ? 255 : b == 2 ? (s % 2 ? 15 : 240) : b == 1 ? 192 >> (2 * s) : 0;
  endfunction
  function automatic int lsb(int s, int b);
    return b == 2 ? (s % 2 ? 0 : 4) : b == 1 ? 6 - 2 * s : 0;
  endfunction
  function automatic int src(int p);
    if (p > 3 || (mode == 1 && p > 1) || (mode == 2 && p > 0)) return -1;
    return mode == 0 ? p : p + 2 * ((cis >> p) & 1);
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (exp !== got) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_rd <= 1'b0;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", exp, o_rdata);
    @(posedge i_sys_clk);
  endtask
  task automatic cfg(input int m, input int d);
    int adj, code, s[4];
    logic sy;
    logic [3:0] us;
    mode = m;
    od = d;
    cis = (m == 0) ? 0 : {$random(seed)} % (m == 1 ? 4 : 2);
    adj = {$random(seed)} % 6;
    code = {$random(seed)} % 8;
    sy = 1'($random(seed));
    us = 4'($random(seed));
    for (int p = 0; p < 4; p++) begin
      s[p] = {$random(seed)} % 4;
      if (m > 0) s[p] = s[m == 1 ? p % 2 : 0];
      if (m == 0 && d == 0) s[p] = 0;
      sel[p] <= s[p];
      bw[p] <= {$random(seed)} % 4;
      tx_tab[p] <= 8'($random(seed));
      for (int l = 0; l < 4; l++) up_bytes[p][l] <= 8'($random(seed));
    end
    sync <= sy;
    ushift <= us;
    mark <= 5'((adj - 2) * 8 + code - 2);
    wr(CTI_ADDR_MODE1, {3'h0, sy, 2'(cis), 2'(m)});
    wr(CTI_ADDR_MODE2, 8'($random(seed)) & 8'hf0);
    wr(CTI_ADDR_BITS_LO, 8'h1f);
    wr(CTI_ADDR_SHIFT, {1'b0, 3'(code), us});
    wr(CTI_ADDR_ADJUST, 8'(adj));
    wr(CTI_ADDR_SUBSEL, {2'(s[3]), 2'(s[2]), 2'(s[1]), 2'(s[0])});
    wr(CTI_ADDR_OPMODE, 8'(d * 8));
    i_wr <= 1'b0;
  endtask
  task automatic check_down;
    int m, x, b, eo, el;
    for (int c = 0; c < 32; c++) begin
      eo = 0;
      el = 15;
      b = 7 - c % 8;
      for (int p = 0; p < 4; p++) begin
        m = (src(p) >= 0) ? msk(sel[p], bw[p]) : 0;
        x = ((tx_tab[c / 8] ^ p) << lsb(sel[p], bw[p])) & m;
        if (m[b]) begin
          el[p] = x[b];
          eo[p] = od ? !x[b] : 1;
        end
      end
      chk("down pins", 8'({eo[3:0], el[3:0]}), far.seen[c]);
    end
  endtask
  always @(posedge i_sys_clk) begin
    int s, m, e;
    if (chk_en && o_rx_valid === 1'b1) begin
      for (int p = 0; p < 8; p++) begin
        s = src(p);
        m = msk(sel[p % 4], bw[p % 4]);
        e = s < 0 ? 0 : (up_bytes[o_rx_slot[1:0]][s] & m) >> lsb(sel[p % 4], bw[p % 4]);
        chk("rx data", 8'(e), o_rx_data[p]);
      end
    end
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    failures++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    foreach (rst_v[a]) rd(4'(a), rst_v[a]);
    for (int a = 8; a < 16; a++) rd(4'(a), 8'h00);
    for (int a = 0; a < 6; a++) begin
      v = 8'($random(seed));
      wr(4'(a), v);
      rd(4'(a), v & rw_m[a]);
    end
    $display("test registers done");
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cfg(i % 3, i % 2);
      repeat (600) @(posedge i_sys_clk);
      chk_en <= 1'b1;
      repeat (300) @(posedge i_sys_clk);
      chk_en <= 1'b0;
      check_down;
      $display("test traffic mode %0d done", i % 3);
    end
    finish_test;
  end
endmodule
